// ### pkg/ofscd_cfg.svh
`ifndef OFSCD_CFG_SVH
`define OFSCD_CFG_SVH
// Opcodes
`define OFSCD_OP_CONTRAST   8'h81
`define OFSCD_OP_ENTIRE     7'h52
`define OFSCD_OP_INVERSE    7'h53
`define OFSCD_OP_DISPLAY    7'h57
`define OFSCD_OP_NOP        8'hE3
`define OFSCD_OP_LOCK       8'hFD
`define OFSCD_OP_SCROLL     7'h16
// Reset values
`define OFSCD_CONTRAST_RST  8'h7F
// Field positions
`define OFSCD_LOCK_BIT      2
// Parameter count and end-page parameter index
`define OFSCD_SCROLL_NPARAM 3'h7
`define OFSCD_LAST_PAGE     3'h3
// Register offsets
`define OFSCD_ADDR_CMD      4'h0
`define OFSCD_ADDR_CFG      4'h4
`define OFSCD_ADDR_SCROLL   4'h8
`define OFSCD_ADDR_STATUS   4'hC
// Bus answers
`define OFSCD_RESP_OKAY     2'h0
`define OFSCD_RESP_SLVERR   2'h2
`endif

// ### pkg/ofscd_pkg.sv
package ofscd_pkg;
  typedef enum logic [1:0] {
    OFSCD_IDLE  = 2'h0,
    OFSCD_PARAM = 2'h1
  } ofscd_state_e;
  typedef enum logic [1:0] {
    OFSCD_K_CONTRAST = 2'h0,
    OFSCD_K_LOCK     = 2'h1,
    OFSCD_K_SCROLL   = 2'h3
  } ofscd_kind_e;
endpackage

// ### design/ofscd_decoder.sv
`timescale 1ns/1ps
`include "ofscd_cfg.svh"
// Overview of operation
// - Contrast is opcode then one 8-bit level out of 256.
// - Contrast output rises with parameter; resets to 7Fh.
// - Entire-display opcode bit0 clear shows RAM; reset state.
// - Entire-display opcode bit0 set lights every pixel.
// - Normal polarity (reset): RAM 0 off, RAM 1 on.
// - Inverse polarity: RAM 0 on, RAM 1 off.
// - Display-off opcode sleeps the panel; reset state.
// - Display-on opcode turns the panel on in normal mode.
// - No-operation opcode changes nothing.
// - Lock command is opcode plus parameter; bit 2 set locks.
// - Lock bit 2 clear unlocks; unlocked after reset.
// - Locked: all commands and data ignored except the lock opcode.
// - Scroll opcode bit0 clear shifts right one column.
// - Scroll opcode bit0 set shifts left one column.
// - Start page is low three bits of second scroll parameter.
// - Data/command low means command byte, high means display data.
// - Reset returns every setting to its reset value.
module ofscd_decoder (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // AXI4-Lite write address
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Panel settings
  output logic [7:0]        contrast,
  output logic              entire_on,
  output logic              inverse,
  output logic              display_on,
  output logic              locked,
  // Scroll setup
  output logic              scroll_start,
  output logic              scroll_left,
  output logic [2:0]        scroll_start_page,
  output logic [7:0]        scroll_interval,
  output logic [2:0]        scroll_end_page,
  output logic [7:0]        scroll_col_start,
  output logic [7:0]        scroll_col_end,
  // Display data passed to memory
  output logic              ram_wr,
  output logic [7:0]        ram_data
);
  import ofscd_pkg::*;

  // Bus handshake state
  logic        aw_reg, aw_next;
  logic [3:0]  awa_reg, awa_next;
  logic        w_reg, w_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0]  ws_reg, ws_next;
  logic        bv_reg, bv_next;
  logic [1:0]  br_reg, br_next;
  logic        rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0]  rr_reg, rr_next;
  // Decoder state
  ofscd_state_e st_reg, st_next;
  ofscd_kind_e  kind_reg, kind_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [7:0]  con_reg, con_next;
  logic        ent_reg, ent_next;
  logic        inv_reg, inv_next;
  logic        don_reg, don_next;
  logic        lck_reg, lck_next;
  logic        sgo_reg, sgo_next;
  logic        sl_reg, sl_next;
  logic        sl_pend_reg, sl_pend_next;
  logic [7:0]  sp_reg [0:6];
  logic [7:0]  sp_next [0:6];
  logic        rw_reg, rw_next;
  logic [7:0]  rdat_reg, rdat_next;
  logic        ign_reg, ign_next;
  // Byte strobe from a completed write
  logic        byte_vld;
  logic        byte_dc;
  logic [7:0]  byte_val;

  // Write of the command/data register completes a byte
  always_comb begin
    byte_vld = aw_reg && w_reg && !bv_reg && (awa_reg == `OFSCD_ADDR_CMD) && ws_reg[0];
    byte_dc  = wd_reg[8];
    byte_val = wd_reg[7:0];
  end

  // Bus slave next state
  always_comb begin
    aw_next  = aw_reg;
    awa_next = awa_reg;
    w_next   = w_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next  = 1'b1;
      awa_next = {s_axi_awaddr[3:2], 2'h0};
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next  = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (aw_reg && w_reg && !bv_reg) begin
      bv_next = 1'b1;
      aw_next = 1'b0;
      w_next  = 1'b0;
      if (awa_reg == `OFSCD_ADDR_CMD) begin
        br_next = `OFSCD_RESP_OKAY;
      end else begin
        br_next = `OFSCD_RESP_SLVERR;
      end
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = `OFSCD_RESP_OKAY;
      if ({s_axi_araddr[3:2], 2'h0} == `OFSCD_ADDR_CMD) begin
        rd_next = 32'h0;
      end else if ({s_axi_araddr[3:2], 2'h0} == `OFSCD_ADDR_CFG) begin
        rd_next = {20'h0, lck_reg, don_reg, inv_reg, ent_reg, con_reg};
      end else if ({s_axi_araddr[3:2], 2'h0} == `OFSCD_ADDR_SCROLL) begin
        rd_next = {sp_reg[6], sp_reg[5], 5'h0, sp_reg[3][2:0], sl_reg, 4'h0, sp_reg[1][2:0]};
      end else begin
        rd_next = {28'h0, ign_reg, cnt_reg == 3'h0 ? 1'b0 : 1'b1, kind_reg};
      end
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  // Command decoder next state
  always_comb begin
    st_next      = st_reg;
    kind_next    = kind_reg;
    cnt_next     = cnt_reg;
    con_next     = con_reg;
    ent_next     = ent_reg;
    inv_next     = inv_reg;
    don_next     = don_reg;
    lck_next     = lck_reg;
    sgo_next     = 1'b0;
    sl_next      = sl_reg;
    sl_pend_next = sl_pend_reg;
    sp_next      = sp_reg;
    rw_next      = 1'b0;
    rdat_next    = rdat_reg;
    ign_next     = ign_reg;
    if (byte_vld) begin
      if (byte_dc) begin
        if (lck_reg) begin
          ign_next = 1'b1;
        end else begin
          rw_next   = 1'b1;
          rdat_next = byte_val;
        end
      end else begin
        case (st_reg)
          OFSCD_IDLE: begin
            if (byte_val == `OFSCD_OP_LOCK) begin
              kind_next = OFSCD_K_LOCK;
              cnt_next  = 3'h1;
              st_next   = OFSCD_PARAM;
            end else if (lck_reg) begin
              ign_next = 1'b1;
            end else if (byte_val == `OFSCD_OP_CONTRAST) begin
              kind_next = OFSCD_K_CONTRAST;
              cnt_next  = 3'h1;
              st_next   = OFSCD_PARAM;
            end else if (byte_val[7:1] == `OFSCD_OP_ENTIRE) begin
              ent_next = byte_val[0];
            end else if (byte_val[7:1] == `OFSCD_OP_INVERSE) begin
              inv_next = byte_val[0];
            end else if (byte_val[7:1] == `OFSCD_OP_DISPLAY) begin
              don_next = byte_val[0];
            end else if (byte_val[7:1] == `OFSCD_OP_SCROLL) begin
              kind_next    = OFSCD_K_SCROLL;
              sl_pend_next = byte_val[0];
              cnt_next     = `OFSCD_SCROLL_NPARAM;
              st_next      = OFSCD_PARAM;
            end
            // Other opcodes, the no-operation among them, leave state alone
          end
          OFSCD_PARAM: begin
            cnt_next = cnt_reg - 3'h1;
            if (kind_reg == OFSCD_K_CONTRAST) begin
              con_next = byte_val;
            end else if (kind_reg == OFSCD_K_LOCK) begin
              lck_next = byte_val[`OFSCD_LOCK_BIT];
            end else begin
              sp_next[`OFSCD_SCROLL_NPARAM - cnt_reg] = byte_val;
            end
            if (cnt_reg == 3'h1) begin
              st_next = OFSCD_IDLE;
              if (kind_reg == OFSCD_K_SCROLL) begin
                sgo_next = 1'b1;
                sl_next  = sl_pend_reg;
              end
            end
          end
          default: begin
            st_next = OFSCD_IDLE;
          end
        endcase
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_reg      <= 1'b0;
      awa_reg     <= 4'h0;
      w_reg       <= 1'b0;
      wd_reg      <= 32'h0;
      ws_reg      <= 4'h0;
      bv_reg      <= 1'b0;
      br_reg      <= `OFSCD_RESP_OKAY;
      rv_reg      <= 1'b0;
      rd_reg      <= 32'h0;
      rr_reg      <= `OFSCD_RESP_OKAY;
      st_reg      <= OFSCD_IDLE;
      kind_reg    <= OFSCD_K_CONTRAST;
      cnt_reg     <= 3'h0;
      con_reg     <= `OFSCD_CONTRAST_RST;
      ent_reg     <= 1'b0;
      inv_reg     <= 1'b0;
      don_reg     <= 1'b0;
      lck_reg     <= 1'b0;
      sgo_reg     <= 1'b0;
      sl_reg      <= 1'b0;
      sl_pend_reg <= 1'b0;
      for (int i = 0; i < 7; i++) begin
        sp_reg[i] <= 8'h0;
      end
      rw_reg      <= 1'b0;
      rdat_reg    <= 8'h0;
      ign_reg     <= 1'b0;
    end else begin
      aw_reg      <= aw_next;
      awa_reg     <= awa_next;
      w_reg       <= w_next;
      wd_reg      <= wd_next;
      ws_reg      <= ws_next;
      bv_reg      <= bv_next;
      br_reg      <= br_next;
      rv_reg      <= rv_next;
      rd_reg      <= rd_next;
      rr_reg      <= rr_next;
      st_reg      <= st_next;
      kind_reg    <= kind_next;
      cnt_reg     <= cnt_next;
      con_reg     <= con_next;
      ent_reg     <= ent_next;
      inv_reg     <= inv_next;
      don_reg     <= don_next;
      lck_reg     <= lck_next;
      sgo_reg     <= sgo_next;
      sl_reg      <= sl_next;
      sl_pend_reg <= sl_pend_next;
      sp_reg      <= sp_next;
      rw_reg      <= rw_next;
      rdat_reg    <= rdat_next;
      ign_reg     <= ign_next;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready     = !aw_reg;
  assign s_axi_wready      = !w_reg;
  assign s_axi_bvalid      = bv_reg;
  assign s_axi_bresp       = br_reg;
  assign s_axi_arready     = !rv_reg;
  assign s_axi_rvalid      = rv_reg;
  assign s_axi_rdata       = rd_reg;
  assign s_axi_rresp       = rr_reg;
  assign contrast          = con_reg;
  assign entire_on         = ent_reg;
  assign inverse           = inv_reg;
  assign display_on        = don_reg;
  assign locked            = lck_reg;
  assign scroll_start      = sgo_reg;
  assign scroll_left       = sl_reg;
  assign scroll_start_page = sp_reg[1][2:0];
  assign scroll_interval   = sp_reg[2];
  assign scroll_end_page   = sp_reg[`OFSCD_LAST_PAGE][2:0];
  assign scroll_col_start  = sp_reg[5];
  assign scroll_col_end    = sp_reg[6];
  assign ram_wr            = rw_reg;
  assign ram_data          = rdat_reg;
endmodule

// ### verification/ofscd_decoder_asserts.sv
`timescale 1ns/1ps
`include "ofscd_cfg.svh"
module ofscd_decoder_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // Settings and pulses
  input wire logic [7:0]  contrast,
  input wire logic        entire_on,
  input wire logic        inverse,
  input wire logic        display_on,
  input wire logic        locked,
  input wire logic        scroll_start,
  input wire logic        ram_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Moment a write response is issued
  sequence s_resp;
    $rose(s_axi_bvalid);
  endsequence
  // Checks on settings, pulses and bus timing
  a_reset_state: assert property (disable iff (1'b0)
    !rst_n |=> contrast == `OFSCD_CONTRAST_RST && !display_on && !locked && !entire_on && !inverse)
    else $error("settings not at reset values");
  a_apply_on_resp: assert property (
    $changed({contrast, entire_on, inverse, display_on, locked}) |-> s_resp)
    else $error("setting changed outside a write response");
  a_scroll_pulse: assert property (scroll_start |-> s_resp ##1 !scroll_start)
    else $error("scroll pulse malformed");
  a_ram_pulse: assert property (ram_wr |-> s_resp ##1 !ram_wr)
    else $error("memory write pulse malformed");
  a_lock_holds: assert property ($past(locked) && locked |->
    $stable({contrast, entire_on, inverse, display_on}) && !ram_wr && !scroll_start)
    else $error("state changed while locked");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_cfg_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFSCD_ADDR_CFG
    |=> s_axi_rvalid && s_axi_rdata[7:0] == contrast)
    else $error("contrast readback wrong");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready while busy");
endmodule
bind ofscd_decoder ofscd_decoder_chk u_chk (.*);

// ### verification/ofscd_host.sv
`timescale 1ns/1ps
`include "ofscd_cfg.svh"
module ofscd_host #(
  parameter int FRAME_GAP = 40  // Cycles standing in for two frame periods
) (
  // Clock
  input  wire logic        clk,
  // Write channels
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [3:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
  end
  // One write; released payload is inverted so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    bit pa, pw, pb;
    {pa, pw, pb} = 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (pa || pw || pb) begin
      @(posedge clk);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (pb && s_axi_bvalid) begin
        pb = 0;
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
    end
    @(posedge clk); // Idle edge: next call never re-drives bready in the same step
  endtask
  // One read
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bit pa, pr;
    {pa, pr} = 2'h3;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (pa || pr) begin
      @(posedge clk);
      if (pa && s_axi_arready) begin
        pa = 0;
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (pr && s_axi_rvalid) begin
        pr = 0;
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
      end
    end
    @(posedge clk); // Idle edge: next call never re-drives rready in the same step
  endtask
  // One command or data byte
  task automatic cmd(input logic dc, input logic [7:0] b);
    logic [1:0] r;
    wr(`OFSCD_ADDR_CMD, {23'h0, dc, b}, 4'h1, r);
  endtask
  // Full scroll setup, keeping the host's ordering duties
  task automatic scroll(input logic left, input logic [7:0] sp, iv, ep, cs, ce);
    if (ep[2:0] < sp[2:0]) ep[2:0] = sp[2:0];
    if (ce <= cs) ce = cs + 8'h01;
    cmd(1'b0, {`OFSCD_OP_SCROLL, left});
    cmd(1'b0, 8'h00);
    cmd(1'b0, sp);
    cmd(1'b0, iv);
    cmd(1'b0, ep);
    cmd(1'b0, 8'h00);
    cmd(1'b0, cs);
    cmd(1'b0, ce);
    repeat (FRAME_GAP) @(posedge clk);
  endtask
endmodule

// ### verification/test_oled_fundamental_scroll_cmd_decoder.sv
`timescale 1ns/1ps
`include "ofscd_cfg.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module test_oled_fundamental_scroll_cmd_decoder;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, entire_on, inverse, display_on, locked, scroll_start;
  logic        scroll_left, ram_wr;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [2:0]  scroll_start_page, scroll_end_page;
  logic [7:0]  contrast, scroll_interval, scroll_col_start, scroll_col_end, ram_data;
  logic [7:0]  last_ram = 8'h00;
  logic [7:0]  ops [7] = '{8'hA5, 8'hA7, 8'hAF, 8'hE3, 8'hA4, 8'hA6, 8'hAE};
  logic [2:0]  modes [7] = '{3'h1, 3'h3, 3'h7, 3'h7, 3'h6, 3'h4, 3'h0};
  int          num_errors = 0, cmp_count = 0, n_scroll = 0;
  ofscd_decoder dut (.*);
  ofscd_host host (.*);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Capture of memory bytes and scroll pulses
  always @(posedge clk) begin
    if (ram_wr) last_ram <= ram_data;
    if (scroll_start) n_scroll <= n_scroll + 1;
  end
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    host.rd(`OFSCD_ADDR_CFG, rdv); `CHK(rdv, 32'h0000007F)
    `CHK(s_axi_rresp, `OFSCD_RESP_OKAY)
    host.cmd(1'b0, `OFSCD_OP_CONTRAST); `CHK(contrast, 8'h7F)
    host.cmd(1'b0, 8'h00); `CHK(contrast, 8'h00)
    host.cmd(1'b0, `OFSCD_OP_CONTRAST);
    host.cmd(1'b0, 8'hFF); `CHK(contrast, 8'hFF)
    for (int i = 0; i < 7; i++) begin
      host.cmd(1'b0, ops[i]);
      host.rd(`OFSCD_ADDR_CFG, rdv); `CHK(rdv[10:0], {modes[i], 8'hFF})
    end
    host.cmd(1'b1, 8'h5A); `CHK(last_ram, 8'h5A)
    // Locked interface drops everything but the unlock
    host.cmd(1'b0, `OFSCD_OP_LOCK);
    host.cmd(1'b0, 8'h04); `CHK(locked, 1'b1)
    host.cmd(1'b0, `OFSCD_OP_CONTRAST);
    host.cmd(1'b0, 8'h10);
    host.cmd(1'b0, 8'hAF);
    host.cmd(1'b1, 8'h33);
    host.rd(`OFSCD_ADDR_CFG, rdv); `CHK(rdv[11:0], 12'h8FF)
    `CHK(last_ram, 8'h5A)
    host.rd(`OFSCD_ADDR_STATUS, rdv); `CHK(rdv[3], 1'b1)
    host.cmd(1'b0, `OFSCD_OP_LOCK);
    host.cmd(1'b0, 8'hFB); `CHK(locked, 1'b0)
    // Both scroll directions, page fields with high bits set
    for (int l = 0; l < 2; l++) begin
      host.scroll(l[0], 8'hF9, 8'h07, 8'hFD, 8'h10, 8'h20);
      host.rd(`OFSCD_ADDR_SCROLL, rdv);
      `CHK(rdv, {8'h20, 8'h10, 5'h00, 3'h5, l[0], 4'h0, 3'h1})
      `CHK(scroll_interval, 8'h07)
      `CHK({scroll_left, scroll_start_page, scroll_end_page}, {l[0], 3'h1, 3'h5})
      `CHK({scroll_col_start, scroll_col_end}, 16'h1020)
    end
    `CHK(n_scroll, 2)
    // Unmapped address and empty strobe
    host.wr(`OFSCD_ADDR_CFG, 32'h000000A7, 4'hF, resp); `CHK(resp, `OFSCD_RESP_SLVERR)
    host.wr(`OFSCD_ADDR_CMD, 32'h000000A7, 4'h0, resp); `CHK(inverse, 1'b0)
    `CHK(resp, `OFSCD_RESP_OKAY)
    // Reset in mid-run
    host.cmd(1'b0, `OFSCD_OP_CONTRAST);
    host.cmd(1'b0, 8'h22);
    host.cmd(1'b0, 8'hAF);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    host.rd(`OFSCD_ADDR_CFG, rdv); `CHK(rdv[11:0], 12'h07F)
    complete_run();
  end
endmodule
